// File: hrw_host.sv
`timescale 1ns/100ps
`include "hrw_cfg.svh"
module hrw_host #(
  parameter int ADDR_W = 8,
  parameter int BURST_MAX = `HRW_BURST_MAX,
  parameter logic [ADDR_W-1:0] PWR_MGMT_ADDR = 8'h84,
  parameter logic [ADDR_W-1:0] FREE_RUN_ADDR = 8'h9C,
  parameter logic [ADDR_W-1:0] TX_INFO_ADDR = 8'h80,
  parameter logic [ADDR_W-1:0] IRQ_CFG_ADDR = 8'h54,
  parameter logic [ADDR_W-1:0] TIMER_CNT_ADDR = 8'h90,
  parameter logic [ADDR_W-1:0] IRQ_STS_ADDR = 8'h58,
  parameter logic [ADDR_W-1:0] ID_ADDR = 8'h50,
  parameter logic [ADDR_W-1:0] BYTE_TEST_ADDR = 8'h64,
  parameter logic [ADDR_W-1:0] RX_INFO_ADDR = 8'h7C,
  parameter logic [ADDR_W-1:0] RX_DROP_ADDR = 8'hA0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire hrw_pkg::hrw_cmd_t req_cmd,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic [4:0] req_len,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_last,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic queue_select,
  output logic [ADDR_W-1:0] addr,
  output logic [15:0] data_out,
  output logic data_oe,
  input wire logic [15:0] data_in
);
  // one word per address cycle: a bare 32 ns low time would let burst words come too fast
  localparam int LOW_CYC = `HRW_CYC_MIN(`HRW_CYCLE_NS);
  localparam int HIGH_CYC = `HRW_CYC_MIN(`HRW_STROBE_HIGH_NS);
  localparam int W_SHORT = `HRW_CYC_MIN(`HRW_WAIT_SHORT_NS);
  localparam int W_IRQ = `HRW_CYC_MIN(`HRW_WAIT_IRQSTS_NS);
  localparam int W_LONG = `HRW_CYC_MIN(`HRW_WAIT_LONG_NS);
  localparam int W_FREE = `HRW_CYC_MIN(`HRW_WAIT_FREERUN_NS);
  localparam int W_PWR = `HRW_CYC_MIN(`HRW_WAIT_PWRMGMT_NS);

  hrw_pkg::hrw_state_t state_r;
  hrw_pkg::hrw_cmd_t cmd_r;
  logic [ADDR_W-1:0] addr_r;
  logic [15:0] wdata_r;
  logic [4:0] left_r;
  logic [3:0] phase_r;
  logic [15:0] din_s1_r;
  logic [15:0] din_s2_r;
  logic [8:0] since_wr_r;
  logic wr_seen_r;
  logic [8:0] need_cyc;
  logic is_write;
  logic hold_zero;
  logic hold_load;
  logic [8:0] hold_val;

  assign is_write = (req_cmd == hrw_pkg::HRW_CMD_WRITE) ||
                    (req_cmd == hrw_pkg::HRW_CMD_QUEUE_WRITE);

  // wait class chosen by the read target, counted from the end of the last write
  always_comb begin
    need_cyc = 9'h000;
    if (req_addr == PWR_MGMT_ADDR) begin
      need_cyc = 9'(W_PWR);
    end else if (req_addr == FREE_RUN_ADDR) begin
      need_cyc = 9'(W_FREE);
    end else if (req_addr == TX_INFO_ADDR) begin
      need_cyc = 9'(W_LONG);
    end else if (req_addr == IRQ_CFG_ADDR || req_addr == TIMER_CNT_ADDR) begin
      need_cyc = 9'(W_LONG);
    end else if (req_addr == IRQ_STS_ADDR) begin
      need_cyc = 9'(W_IRQ);
    end else if (req_addr == ID_ADDR || req_addr == BYTE_TEST_ADDR ||
                 req_addr == RX_INFO_ADDR || req_addr == RX_DROP_ADDR) begin
      need_cyc = 9'h000;
    end else begin
      need_cyc = 9'(W_SHORT);
    end
  end

  // remaining hold-off; strobe recovery time already spent counts toward it
  always_comb begin
    hold_val = 9'h000;
    if (!is_write && wr_seen_r && need_cyc > since_wr_r) begin
      hold_val = need_cyc - since_wr_r;
    end
  end
  assign hold_load = (state_r == hrw_pkg::HRW_ST_IDLE) && req_valid;

  hrw_cnt #(.W(9)) u_hold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(hold_load),
    .load_val(hold_val),
    .zero(hold_zero)
  );

  assign req_ready = (state_r == hrw_pkg::HRW_ST_IDLE);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      din_s1_r <= 16'h0000;
      din_s2_r <= 16'h0000;
    end else begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  // elapsed cycles since the last write strobe released; saturates
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      since_wr_r <= 9'h1FF;
      wr_seen_r <= 1'b0;
    end else if (state_r == hrw_pkg::HRW_ST_STROBE && !write_strobe_n) begin
      since_wr_r <= 9'h000;
      wr_seen_r <= 1'b1;
    end else if (since_wr_r != 9'h1FF) begin
      since_wr_r <= since_wr_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= hrw_pkg::HRW_ST_IDLE;
      cmd_r <= hrw_pkg::HRW_CMD_READ;
      addr_r <= '0;
      wdata_r <= 16'h0000;
      left_r <= 5'h00;
      phase_r <= 4'h0;
    end else begin
      case (state_r)
        hrw_pkg::HRW_ST_IDLE: begin
          if (req_valid) begin
            cmd_r <= req_cmd;
            addr_r <= req_addr;
            wdata_r <= req_wdata;
            if (req_cmd == hrw_pkg::HRW_CMD_BURST_READ ||
                req_cmd == hrw_pkg::HRW_CMD_QUEUE_BURST) begin
              left_r <= (req_len == 5'h00 || req_len > 5'(BURST_MAX)) ?
                        5'(BURST_MAX) : req_len;
            end else begin
              left_r <= 5'h01;
            end
            state_r <= hrw_pkg::HRW_ST_HOLDOFF;
          end
        end
        hrw_pkg::HRW_ST_HOLDOFF: begin
          if (hold_zero) begin
            state_r <= hrw_pkg::HRW_ST_SETUP;
          end
        end
        hrw_pkg::HRW_ST_SETUP: begin
          phase_r <= 4'h0;
          state_r <= hrw_pkg::HRW_ST_STROBE;
        end
        hrw_pkg::HRW_ST_STROBE: begin
          phase_r <= phase_r + 4'h1;
          if (phase_r == 4'(LOW_CYC - 1)) begin
            phase_r <= 4'h0;
            left_r <= left_r - 5'h01;
            if (left_r == 5'h01) begin
              state_r <= hrw_pkg::HRW_ST_RECOVER;
            end else begin
              addr_r <= addr_r + ADDR_W'(2);
            end
          end
        end
        hrw_pkg::HRW_ST_RECOVER: begin
          phase_r <= phase_r + 4'h1;
          if (phase_r == 4'(HIGH_CYC - 1)) begin
            state_r <= hrw_pkg::HRW_ST_DONE;
          end
        end
        hrw_pkg::HRW_ST_DONE: begin
          state_r <= hrw_pkg::HRW_ST_IDLE;
        end
        default: begin
          state_r <= hrw_pkg::HRW_ST_IDLE;
        end
      endcase
    end
  end

  // pin drive: reads by read strobe low, writes by write strobe low; queue select on queue modes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chip_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      queue_select <= 1'b0;
      addr <= '0;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
    end else begin
      // at a burst word boundary the pins move on together with addr_r, not a word late
      if (state_r == hrw_pkg::HRW_ST_STROBE && phase_r == 4'(LOW_CYC - 1) &&
          left_r != 5'h01) begin
        addr <= addr_r + ADDR_W'(2);
      end else begin
        addr <= addr_r;
      end
      queue_select <= (cmd_r == hrw_pkg::HRW_CMD_QUEUE_READ) ||
                      (cmd_r == hrw_pkg::HRW_CMD_QUEUE_BURST) ||
                      (cmd_r == hrw_pkg::HRW_CMD_QUEUE_WRITE);
      data_out <= wdata_r;
      if (state_r == hrw_pkg::HRW_ST_SETUP ||
          (state_r == hrw_pkg::HRW_ST_STROBE &&
           !(phase_r == 4'(LOW_CYC - 1) && left_r == 5'h01))) begin
        chip_select_n <= 1'b0;
        read_strobe_n <= !(cmd_r inside {hrw_pkg::HRW_CMD_READ, hrw_pkg::HRW_CMD_BURST_READ,
                          hrw_pkg::HRW_CMD_QUEUE_READ, hrw_pkg::HRW_CMD_QUEUE_BURST});
        write_strobe_n <= !(cmd_r == hrw_pkg::HRW_CMD_WRITE ||
                            cmd_r == hrw_pkg::HRW_CMD_QUEUE_WRITE);
        data_oe <= (cmd_r == hrw_pkg::HRW_CMD_WRITE ||
                    cmd_r == hrw_pkg::HRW_CMD_QUEUE_WRITE);
      end else begin
        chip_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        data_oe <= 1'b0;
      end
    end
  end

  // sample at the end of each strobe word; synchroniser adds two cycles of latency
  logic [2:0] cap_pipe_r;
  logic [2:0] last_pipe_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cap_pipe_r <= 3'h0;
      last_pipe_r <= 3'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_last <= 1'b0;
    end else begin
      cap_pipe_r <= {cap_pipe_r[1:0], (state_r == hrw_pkg::HRW_ST_STROBE &&
                     phase_r == 4'(LOW_CYC - 1) && !read_strobe_n)};
      last_pipe_r <= {last_pipe_r[1:0], (left_r == 5'h01)};
      rsp_valid <= cap_pipe_r[1];
      rsp_last <= cap_pipe_r[1] && last_pipe_r[1];
      if (cap_pipe_r[1]) begin
        rsp_rdata <= din_s2_r;
      end
    end
  end
endmodule

// File: hrw_cfg.svh
`ifndef HRW_CFG_SVH
`define HRW_CFG_SVH

`define HRW_CLK_MHZ 25
`define HRW_WAIT_NONE_NS 0
`define HRW_WAIT_SHORT_NS 45
`define HRW_WAIT_IRQSTS_NS 90
`define HRW_WAIT_LONG_NS 135
`define HRW_WAIT_FREERUN_NS 180
`define HRW_WAIT_PWRMGMT_NS 315
`define HRW_NS_TO_CYC(ns) ((((ns) * `HRW_CLK_MHZ) + 999) / 1000)
`define HRW_CYC_MIN(ns) ((`HRW_NS_TO_CYC(ns) < 1) ? 1 : `HRW_NS_TO_CYC(ns))
`define HRW_STROBE_LOW_NS 32
`define HRW_STROBE_HIGH_NS 13
`define HRW_DATA_VALID_NS 30
`define HRW_CYCLE_NS 45
`define HRW_BURST_MAX 16

`endif

// File: hrw_pkg.sv
package hrw_pkg;
  typedef enum logic [4:0] {
    HRW_CLS_ZERO = 5'h01,
    HRW_CLS_SHORT = 5'h02,
    HRW_CLS_IRQSTS = 5'h04,
    HRW_CLS_LONG = 5'h08,
    HRW_CLS_FREERUN = 5'h10
  } hrw_cls_t;
  typedef enum logic [2:0] {
    HRW_CMD_READ = 3'h0,
    HRW_CMD_BURST_READ = 3'h1,
    HRW_CMD_QUEUE_READ = 3'h2,
    HRW_CMD_QUEUE_BURST = 3'h3,
    HRW_CMD_WRITE = 3'h4,
    HRW_CMD_QUEUE_WRITE = 3'h5
  } hrw_cmd_t;
  typedef enum logic [5:0] {
    HRW_ST_IDLE = 6'h01,
    HRW_ST_HOLDOFF = 6'h02,
    HRW_ST_SETUP = 6'h04,
    HRW_ST_STROBE = 6'h08,
    HRW_ST_RECOVER = 6'h10,
    HRW_ST_DONE = 6'h20
  } hrw_state_t;
endpackage

// File: hrw_cnt.sv
`timescale 1ns/100ps
`include "hrw_cfg.svh"
module hrw_cnt #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);
  logic [W-1:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign zero = (cnt_r == '0);
endmodule

// File: hrw_host_properties.sv
`timescale 1ns/100ps
module hrw_host_chk #(
  parameter int ADDR_W = 8,
  parameter logic [ADDR_W-1:0] PWR_MGMT_ADDR = 8'h84,
  parameter logic [ADDR_W-1:0] FREE_RUN_ADDR = 8'h9C,
  parameter logic [ADDR_W-1:0] TX_INFO_ADDR = 8'h80,
  parameter logic [ADDR_W-1:0] IRQ_STS_ADDR = 8'h58,
  parameter logic [ADDR_W-1:0] CFG_ADDR = 8'h74
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic queue_select,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic data_oe
);
  logic [3:0] gap_r;
  logic rs_r;
  // saturates so a long idle never wraps back into a short gap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) gap_r <= 4'hF;
    else if (!write_strobe_n) gap_r <= 4'h0;
    else if (gap_r != 4'hF) gap_r <= gap_r + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rs_r <= 1'b1;
    else rs_r <= read_strobe_n;
  end
  wire go = rs_r && !read_strobe_n && !queue_select;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_pwr_wait: assert property (go && addr == PWR_MGMT_ADDR |-> gap_r >= 4'h8)
    else $error("early read");
  a_free_wait: assert property (go && addr == FREE_RUN_ADDR |-> gap_r >= 4'h5)
    else $error("early read");
  a_txinfo_wait: assert property (go && addr == TX_INFO_ADDR |-> gap_r >= 4'h4)
    else $error("early read");
  a_irqsts_wait: assert property (go && addr == IRQ_STS_ADDR |-> gap_r >= 4'h3)
    else $error("early read");
  a_cfg_wait: assert property (go && addr == CFG_ADDR |-> gap_r >= 4'h2)
    else $error("early read");
  a_strobe_excl: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  a_write_cs: assert property (!write_strobe_n |-> !chip_select_n && data_oe)
    else $error("bad write pins");
  a_read_oe: assert property (!read_strobe_n |-> !data_oe)
    else $error("drive in read");
  a_read_answer: assert property (go |-> ##[1:60] rsp_valid)
    else $error("no read word");
  a_last_word: assert property (rsp_last |-> rsp_valid)
    else $error("lone last");
endmodule
bind hrw_host hrw_host_chk #(.ADDR_W(ADDR_W), .PWR_MGMT_ADDR(PWR_MGMT_ADDR),
  .FREE_RUN_ADDR(FREE_RUN_ADDR), .TX_INFO_ADDR(TX_INFO_ADDR), .IRQ_STS_ADDR(IRQ_STS_ADDR)) chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .rsp_valid(rsp_valid),
  .rsp_last(rsp_last),
  .chip_select_n(chip_select_n),
  .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n),
  .queue_select(queue_select),
  .addr(addr),
  .data_oe(data_oe)
);

// File: hrw_dev_model.sv
`timescale 1ns/100ps
module hrw_dev_model (
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic queue_select,
  input wire logic [7:0] addr,
  input wire logic [15:0] data_out,
  output logic [15:0] data_in
);
  logic [15:0] mem [128];
  logic [15:0] tx_lvl, rdv, wd;
  logic [7:0] wa;
  logic wq, wcs;
  function automatic int settle(logic [7:0] a);
    case (a)
      8'h50, 8'h64, 8'h7C, 8'hA0: return 0;
      8'h58: return 90;
      8'h54, 8'h80, 8'h90: return 135;
      8'h9C: return 180;
      8'h84: return 315;
      default: return 45;
    endcase
  endfunction
  initial begin
    tx_lvl = 16'h0000;
    for (int i = 0; i < 128; i++) mem[i] = 16'h1000 + 16'(i);
  end
  always @(negedge write_strobe_n) begin
    wa = addr;
    wd = data_out;
    wq = queue_select;
    wcs = !chip_select_n;
  end
  // effects land no sooner than the settle time, so an early read sees stale data
  always @(posedge write_strobe_n) begin
    if (wcs && wq) tx_lvl <= #135 tx_lvl + 16'h0001;
    else if (wcs) mem[wa[7:1]] <= #(settle(wa)) wd;
  end
  always @* rdv = queue_select ? 16'h5A00 + {8'h00, addr} : addr == 8'h80 ? tx_lvl : mem[addr[7:1]];
  // released bus shows the inverse so a late sample cannot match by luck
  assign #30 data_in = (!chip_select_n && !read_strobe_n) ? rdv : ~rdv;
endmodule

// File: hrw_host_test.sv
`timescale 1ns/100ps
module hrw_host_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  hrw_pkg::hrw_cmd_t req_cmd = hrw_pkg::HRW_CMD_READ;
  logic [7:0] req_addr = 8'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic [4:0] req_len = 5'h00;
  logic req_ready, rsp_valid, rsp_last, chip_select_n, read_strobe_n, write_strobe_n;
  logic queue_select, data_oe;
  logic [7:0] addr;
  logic [15:0] rsp_rdata, data_out, data_in, tx_lvl;
  logic [15:0] mem [128];
  logic [15:0] rq [$];
  logic lq [$];
  int miscompares = 0;
  int tests_run = 0;
  always #20 ref_clk = ~ref_clk;
  hrw_host uut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_cmd(req_cmd),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_len(req_len),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .rsp_last(rsp_last),
    .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .queue_select(queue_select),
    .addr(addr),
    .data_out(data_out),
    .data_oe(data_oe),
    .data_in(data_in)
  );
  hrw_dev_model dev (
    .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .queue_select(queue_select),
    .addr(addr),
    .data_out(data_out),
    .data_in(data_in)
  );
  always @(negedge ref_clk) if (rsp_valid === 1'b1) begin
    rq.push_back(rsp_rdata);
    lq.push_back(rsp_last);
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic req(hrw_pkg::hrw_cmd_t c, logic [7:0] a, logic [15:0] d, logic [4:0] n);
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_wdata = d;
    req_len = n;
    for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  function automatic logic [15:0] ex(hrw_pkg::hrw_cmd_t c, logic [7:0] a);
    if (c == hrw_pkg::HRW_CMD_QUEUE_READ || c == hrw_pkg::HRW_CMD_QUEUE_BURST)
      return 16'h5A00 + {8'h00, a};
    return a == 8'h80 ? tx_lvl : mem[a[7:1]];
  endfunction
  task automatic rd(hrw_pkg::hrw_cmd_t c, logic [7:0] a, int n);
    rq.delete();
    lq.delete();
    req(c, a, 16'h0000, 5'(n));
    for (int i = 0; i < 200 && rq.size() < n; i++) @(negedge ref_clk);
    chk("words", 16'(n), 16'(rq.size()));
    for (int i = 0; i < n && i < rq.size(); i++) begin
      chk("rdata", ex(c, a + 8'(2 * i)), rq[i]);
      chk("last", 16'(i == n - 1), 16'(lq[i]));
    end
  endtask
  task automatic wr(hrw_pkg::hrw_cmd_t c, logic [7:0] a, logic [15:0] d);
    req(c, a, d, 5'h00);
    if (c == hrw_pkg::HRW_CMD_WRITE) mem[a[7:1]] = d;
    else tx_lvl++;
  endtask
  task automatic t_settle;
    logic [7:0] al [9] = '{8'h84, 8'h9C, 8'h54, 8'h90, 8'h58, 8'h74, 8'h50, 8'h64, 8'hA0};
    foreach (al[i]) begin
      wr(hrw_pkg::HRW_CMD_WRITE, al[i], 16'hC300 + 16'(i));
      rd(hrw_pkg::HRW_CMD_READ, al[i], 1);
    end
  endtask
  task automatic t_queue;
    wr(hrw_pkg::HRW_CMD_QUEUE_WRITE, 8'h00, 16'hBEEF);
    wr(hrw_pkg::HRW_CMD_QUEUE_WRITE, 8'h00, 16'h1234);
    rd(hrw_pkg::HRW_CMD_READ, 8'h80, 1);
  endtask
  task automatic t_kinds;
    rd(hrw_pkg::HRW_CMD_BURST_READ, 8'hC0, 4);
    rd(hrw_pkg::HRW_CMD_QUEUE_READ, 8'h10, 1);
    rd(hrw_pkg::HRW_CMD_QUEUE_BURST, 8'h20, 16);
    wr(hrw_pkg::HRW_CMD_WRITE, 8'hC2, 16'h0F0F);
    rd(hrw_pkg::HRW_CMD_BURST_READ, 8'hC0, 3);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    tx_lvl = 16'h0000;
    for (int i = 0; i < 128; i++) mem[i] = 16'h1000 + 16'(i);
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    t_settle();
    t_queue();
    t_kinds();
    stop_test();
  end
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
endmodule
